// [hdl/alb_pkg.sv]
// package: operation codes, register offsets and timing counts for the execution slice
package alb_pkg;

   // operation codes written to the opcode register
   typedef enum logic [4:0] {
      OP_NONE           = 5'h00,
      OP_SUM_TWO_REGS   = 5'h01,
      OP_SUM_WITH_CARRY = 5'h02,
      OP_WORD_PLUS_IMM  = 5'h03,
      OP_MINUS_REGS     = 5'h04,
      OP_MINUS_IMM      = 5'h05,
      OP_MINUS_REGS_BOR = 5'h06,
      OP_MINUS_IMM_BOR  = 5'h07,
      OP_WORD_MINUS_IMM = 5'h08,
      OP_CONJ_REGS      = 5'h09,
      OP_CONJ_IMM       = 5'h0A,
      OP_DISJ_REGS      = 5'h0B,
      OP_DISJ_IMM       = 5'h0C,
      OP_XOR_REGS       = 5'h0D,
      OP_ONES_INVERSE   = 5'h0E,
      OP_TWOS_INVERSE   = 5'h0F,
      OP_BITS_SET_MASK  = 5'h10,
      OP_BITS_CLR_MASK  = 5'h11,
      OP_PLUS_ONE       = 5'h12,
      OP_MINUS_ONE      = 5'h13,
      OP_ZERO_SIGN_CHK  = 5'h14,
      OP_ZERO_REGISTER  = 5'h15,
      OP_REL_GOTO       = 5'h16,
      OP_PTR_GOTO       = 5'h17,
      OP_REL_SUBR_ENTRY = 5'h18,
      OP_PTR_SUBR_ENTRY = 5'h19,
      OP_SUBR_EXIT      = 5'h1A,
      OP_IRQ_EXIT       = 5'h1B,
      OP_EQUAL_SKIP     = 5'h1C,
      OP_COMPARE_PLAIN  = 5'h1D,
      OP_COMPARE_BORROW = 5'h1E,
      OP_MINUS_IMM_CMP  = 5'h1F
   } alb_op_e;

   // register byte offsets
   localparam logic [7:0] ALB_OFF_DEST   = 8'h00;
   localparam logic [7:0] ALB_OFF_SRC    = 8'h04;
   localparam logic [7:0] ALB_OFF_DHIGH  = 8'h08;
   localparam logic [7:0] ALB_OFF_FLAGS  = 8'h0C;
   localparam logic [7:0] ALB_OFF_PC     = 8'h10;
   localparam logic [7:0] ALB_OFF_ZPTR   = 8'h14;
   localparam logic [7:0] ALB_OFF_STACK  = 8'h18;
   localparam logic [7:0] ALB_OFF_OPCODE = 8'h1C;
   localparam logic [7:0] ALB_OFF_STATUS = 8'h20;
   localparam logic [7:0] ALB_OFF_OFFSET = 8'h24;

   // flag bit positions
   localparam int ALB_F_C = 0;
   localparam int ALB_F_Z = 1;
   localparam int ALB_F_N = 2;
   localparam int ALB_F_V = 3;
   localparam int ALB_F_S = 4;
   localparam int ALB_F_H = 5;

   // status bit positions
   localparam int ALB_ST_BUSY = 0;
   localparam int ALB_ST_SKIP = 1;

   // constants
   localparam logic [7:0]  ALB_ALL_ONES   = 8'hFF;
   localparam logic [7:0]  ALB_ALL_ZEROS  = 8'h00;
   localparam logic [15:0] ALB_PC_RESET   = 16'h0000;
   localparam logic [7:0]  ALB_FLAG_RESET = 8'h00;

   // cycle counts and skip distances
   localparam logic [2:0] ALB_CYC_ONE    = 3'h1;
   localparam logic [2:0] ALB_CYC_WORD   = 3'h2;
   localparam logic [2:0] ALB_CYC_GOTO   = 3'h2;
   localparam logic [2:0] ALB_CYC_CALL   = 3'h3;
   localparam logic [2:0] ALB_CYC_RETURN = 3'h4;
   localparam logic [2:0] ALB_CYC_SKIP1  = 3'h2;
   localparam logic [2:0] ALB_CYC_SKIP2  = 3'h3;
   localparam logic [15:0] ALB_SKIP_ONE  = 16'h0002;
   localparam logic [15:0] ALB_SKIP_TWO  = 16'h0003;

endpackage : alb_pkg

// [hdl/alb_alu.sv]
// combinational arithmetic and logic unit for the byte operations
module alb_alu
   import alb_pkg::*;
(
   // operation and operands
   input  wire alb_op_e    op_i,
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic [7:0] flags_i,
   // results
   output logic [7:0]      res_o,
   output logic [7:0]      flags_o,
   output logic            write_o
);

   logic [8:0] wide;
   logic [4:0] half;
   logic       cin;
   logic       sub;
   logic       arith;

   always_comb begin
      wide    = 9'h000;
      half    = 5'h00;
      res_o   = a_i;
      flags_o = flags_i;
      write_o = 1'b1;
      arith   = 1'b1;
      sub     = 1'b0;
      cin     = 1'b0;
      case (op_i)
         OP_SUM_TWO_REGS   : begin sub = 1'b0; cin = 1'b0; end
         OP_SUM_WITH_CARRY : begin sub = 1'b0; cin = flags_i[ALB_F_C]; end
         OP_MINUS_REGS, OP_MINUS_IMM : begin sub = 1'b1; cin = 1'b0; end
         OP_COMPARE_PLAIN, OP_MINUS_IMM_CMP : begin
            sub = 1'b1; cin = 1'b0; write_o = 1'b0;
         end
         OP_MINUS_REGS_BOR, OP_MINUS_IMM_BOR : begin sub = 1'b1; cin = flags_i[ALB_F_C]; end
         OP_COMPARE_BORROW : begin sub = 1'b1; cin = flags_i[ALB_F_C]; write_o = 1'b0; end
         OP_TWOS_INVERSE   : begin sub = 1'b1; cin = 1'b0; end
         default           : arith = 1'b0;
      endcase
      if (arith) begin
         // two's inverse is zero minus the operand
         if (op_i == OP_TWOS_INVERSE) begin
            wide = {1'b0, ALB_ALL_ZEROS} - {1'b0, a_i};
            half = {1'b0, ALB_ALL_ZEROS[3:0]} - {1'b0, a_i[3:0]};
            res_o = wide[7:0];
            flags_o[ALB_F_V] = (wide[7:0] == 8'h80);
         end else if (sub) begin
            wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
            half = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
            res_o = wide[7:0];
            flags_o[ALB_F_V] = (a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7]);
         end else begin
            wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
            half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
            res_o = wide[7:0];
            flags_o[ALB_F_V] = (a_i[7] & b_i[7] & ~res_o[7]) | (~a_i[7] & ~b_i[7] & res_o[7]);
         end
         flags_o[ALB_F_C] = wide[8];
         flags_o[ALB_F_H] = half[4];
         flags_o[ALB_F_N] = res_o[7];
         // borrow forms with carry set keep zero only if it was already set
         if (cin && sub) begin
            flags_o[ALB_F_Z] = (res_o == 8'h00) & flags_i[ALB_F_Z];
         end else begin
            flags_o[ALB_F_Z] = (res_o == 8'h00);
         end
      end else begin
         case (op_i)
            OP_CONJ_REGS, OP_CONJ_IMM  : res_o = a_i & b_i;
            OP_DISJ_REGS, OP_DISJ_IMM  : res_o = a_i | b_i;
            OP_XOR_REGS                : res_o = a_i ^ b_i;
            OP_ONES_INVERSE            : res_o = ALB_ALL_ONES - a_i;
            OP_BITS_SET_MASK           : res_o = a_i | b_i;
            OP_BITS_CLR_MASK           : res_o = a_i & (ALB_ALL_ONES - b_i);
            OP_PLUS_ONE                : res_o = a_i + 8'h01;
            OP_MINUS_ONE               : res_o = a_i - 8'h01;
            OP_ZERO_SIGN_CHK           : res_o = a_i & a_i;
            OP_ZERO_REGISTER           : res_o = a_i ^ a_i;
            default                    : write_o = 1'b0;
         endcase
         if (write_o) begin
            flags_o[ALB_F_Z] = (res_o == 8'h00);
            flags_o[ALB_F_N] = res_o[7];
            case (op_i)
               OP_PLUS_ONE  : flags_o[ALB_F_V] = (a_i == 8'h7F);
               OP_MINUS_ONE : flags_o[ALB_F_V] = (a_i == 8'h80);
               default      : flags_o[ALB_F_V] = 1'b0;
            endcase
            if (op_i == OP_ONES_INVERSE) begin
               flags_o[ALB_F_C] = 1'b1;
            end
         end
      end
      if (op_i == OP_ZERO_SIGN_CHK) begin
         write_o = 1'b0;
      end
   end

endmodule : alb_alu

// [hdl/alb_word.sv]
// sixteen bit add or subtract of an immediate to a register pair
module alb_word
   import alb_pkg::*;
(
   // operands
   input  wire logic        sub_i,
   input  wire logic [15:0] pair_i,
   input  wire logic [7:0]  imm_i,
   input  wire logic [7:0]  flags_i,
   // results
   output logic [15:0]      res_o,
   output logic [7:0]       flags_o
);

   logic [16:0] wide;

   always_comb begin
      if (sub_i) begin
         wide = {1'b0, pair_i} - {9'h000, imm_i};
      end else begin
         wide = {1'b0, pair_i} + {9'h000, imm_i};
      end
      res_o   = wide[15:0];
      flags_o = flags_i;
      flags_o[ALB_F_C] = wide[16];
      flags_o[ALB_F_Z] = (wide[15:0] == 16'h0000);
      flags_o[ALB_F_N] = wide[15];
      flags_o[ALB_F_V] = sub_i ? (pair_i[15] & ~wide[15]) : (~pair_i[15] & wide[15]);
      flags_o[ALB_F_S] = flags_o[ALB_F_N] ^ flags_o[ALB_F_V];
   end

endmodule : alb_word

// [hdl/alb_exec.sv]
// execution slice for arithmetic, logic, jump, call, return and skip operations

module alb_exec
   import alb_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o,
   // execution state
   output logic             busy_o,
   output logic [15:0]      pc_o
);

   typedef enum logic [1:0] {
      ALB_IDLE = 2'b00,
      ALB_WAIT = 2'b01
   } alb_state_e;

   alb_state_e  state;
   logic [7:0]  dest;
   logic [7:0]  src;
   logic [7:0]  dhigh;
   logic [7:0]  flags;
   logic [15:0] pc;
   logic [15:0] zptr;
   logic [15:0] stack;
   logic [7:0]  offset;
   alb_op_e     opcode;
   logic        skip_two;
   logic        skipped;
   logic [2:0]  cnt;

   logic        req;
   logic        wr_hit;
   logic        adr_ok;
   logic        start;
   logic [7:0]  alu_res;
   logic [7:0]  alu_flags;
   logic        alu_write;
   logic [15:0] word_res;
   logic [7:0]  word_flags;
   logic        is_word;
   logic [15:0] rel_target;
   logic [2:0]  next_cnt;
   logic [15:0] next_pc;
   logic        next_skipped;

   // operand b chooses register or constant: both sit in the source register
   alb_alu u_alu (
      .op_i    (opcode),
      .a_i     (dest),
      .b_i     (src),
      .flags_i (flags),
      .res_o   (alu_res),
      .flags_o (alu_flags),
      .write_o (alu_write)
   );

   alb_word u_word (
      .sub_i   (opcode == OP_WORD_MINUS_IMM),
      .pair_i  ({dhigh, dest}),
      .imm_i   (src),
      .flags_i (flags),
      .res_o   (word_res),
      .flags_o (word_flags)
   );

   // bus decode
   always_comb begin
      req    = cyc_i & stb_i & ~ack_o & ~err_o;
      adr_ok = 1'b1;
      case (adr_i)
         ALB_OFF_DEST, ALB_OFF_SRC, ALB_OFF_DHIGH, ALB_OFF_FLAGS, ALB_OFF_PC,
         ALB_OFF_ZPTR, ALB_OFF_STACK, ALB_OFF_OPCODE, ALB_OFF_STATUS, ALB_OFF_OFFSET : adr_ok = 1'b1;
         default : adr_ok = 1'b0;
      endcase
      wr_hit = req & adr_ok & we_i & sel_i[0] & (state == ALB_IDLE);
      start  = wr_hit & (adr_i == ALB_OFF_OPCODE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
      end else begin
         ack_o <= req & adr_ok;
         err_o <= req & ~adr_ok;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req) begin
         case (adr_i)
            ALB_OFF_DEST   : dat_o <= {24'h000000, dest};
            ALB_OFF_SRC    : dat_o <= {24'h000000, src};
            ALB_OFF_DHIGH  : dat_o <= {24'h000000, dhigh};
            ALB_OFF_FLAGS  : dat_o <= {24'h000000, flags};
            ALB_OFF_PC     : dat_o <= {16'h0000, pc};
            ALB_OFF_ZPTR   : dat_o <= {16'h0000, zptr};
            ALB_OFF_STACK  : dat_o <= {16'h0000, stack};
            ALB_OFF_OPCODE : dat_o <= {27'h0000000, opcode};
            ALB_OFF_STATUS : dat_o <= {30'h00000000, skipped, state == ALB_WAIT};
            ALB_OFF_OFFSET : dat_o <= {24'h000000, offset};
            default        : dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // operand registers written by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src    <= 8'h00;
         zptr   <= 16'h0000;
         stack  <= 16'h0000;
         offset <= 8'h00;
         skip_two <= 1'b0;
      end else if (wr_hit) begin
         case (adr_i)
            ALB_OFF_SRC    : src <= dat_i[7:0];
            ALB_OFF_ZPTR   : zptr <= dat_i[15:0];
            ALB_OFF_STACK  : stack <= dat_i[15:0];
            ALB_OFF_OFFSET : offset <= dat_i[7:0];
            ALB_OFF_STATUS : skip_two <= dat_i[ALB_ST_SKIP];
            default        : ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         opcode <= OP_NONE;
      end else if (start) begin
         opcode <= alb_op_e'(dat_i[4:0]);
      end
   end

   assign is_word    = (opcode == OP_WORD_PLUS_IMM) | (opcode == OP_WORD_MINUS_IMM);
   assign rel_target = pc + {{8{offset[7]}}, offset} + 16'h0001;

   // cycle count for the operation just issued
   always_comb begin
      next_skipped = 1'b0;
      case (opcode)
         OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM : next_cnt = ALB_CYC_WORD;
         OP_REL_GOTO, OP_PTR_GOTO            : next_cnt = ALB_CYC_GOTO;
         OP_REL_SUBR_ENTRY, OP_PTR_SUBR_ENTRY: next_cnt = ALB_CYC_CALL;
         OP_SUBR_EXIT, OP_IRQ_EXIT           : next_cnt = ALB_CYC_RETURN;
         OP_EQUAL_SKIP : begin
            next_skipped = (dest == src);
            if (dest != src) begin
               next_cnt = ALB_CYC_ONE;
            end else begin
               next_cnt = skip_two ? ALB_CYC_SKIP2 : ALB_CYC_SKIP1;
            end
         end
         default : next_cnt = ALB_CYC_ONE;
      endcase
   end

   always_comb begin
      case (opcode)
         OP_REL_GOTO, OP_REL_SUBR_ENTRY : next_pc = rel_target;
         OP_PTR_GOTO, OP_PTR_SUBR_ENTRY : next_pc = zptr;
         OP_SUBR_EXIT, OP_IRQ_EXIT      : next_pc = stack;
         OP_EQUAL_SKIP : begin
            if (dest == src) begin
               next_pc = pc + (skip_two ? ALB_SKIP_TWO : ALB_SKIP_ONE);
            end else begin
               next_pc = pc + 16'h0001;
            end
         end
         default : next_pc = pc + 16'h0001;
      endcase
   end

   // sequencer: one cycle per operation plus wait for long ones
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ALB_IDLE;
         cnt     <= 3'h0;
         skipped <= 1'b0;
      end else begin
         case (state)
            ALB_IDLE : begin
               if (start) begin
                  state <= ALB_WAIT;
                  cnt   <= 3'h0;
               end
            end
            ALB_WAIT : begin
               if (cnt == 3'h0) begin
                  skipped <= next_skipped;
               end
               if (cnt + 3'h1 >= next_cnt) begin
                  state <= ALB_IDLE;
               end
               cnt <= cnt + 3'h1;
            end
            default : state <= ALB_IDLE;
         endcase
      end
   end

   // program counter advances once, at the first execute cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc <= ALB_PC_RESET;
      end else if (wr_hit && adr_i == ALB_OFF_PC) begin
         pc <= dat_i[15:0];
      end else if (state == ALB_WAIT && cnt == 3'h0) begin
         pc <= next_pc;
      end
   end

   // destination pair and flags updated at the first execute cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dest  <= 8'h00;
         dhigh <= 8'h00;
         flags <= ALB_FLAG_RESET;
      end else if (wr_hit && adr_i == ALB_OFF_DEST) begin
         dest <= dat_i[7:0];
      end else if (wr_hit && adr_i == ALB_OFF_DHIGH) begin
         dhigh <= dat_i[7:0];
      end else if (wr_hit && adr_i == ALB_OFF_FLAGS) begin
         flags <= dat_i[7:0];
      end else if (state == ALB_WAIT && cnt == 3'h0) begin
         if (is_word) begin
            dest  <= word_res[7:0];
            dhigh <= word_res[15:8];
            flags <= word_flags;
         end else if (opcode != OP_EQUAL_SKIP && opcode < OP_REL_GOTO || opcode > OP_EQUAL_SKIP) begin
            if (alu_write) begin
               dest <= alu_res;
            end
            if (opcode != OP_NONE) begin
               flags <= alu_flags;
            end
         end
      end
   end

   assign busy_o = (state == ALB_WAIT);
   assign pc_o   = pc;

endmodule : alb_exec

// [verif/alb_exec_chk.sv]
// checker: bus answers and operation busy timing of the execution slice
module alb_exec_chk
   import alb_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone slave
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   // execution state
   input wire logic        busy_o,
   input wire logic [15:0] pc_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic req;
   logic mapped;
   logic byte_op;
   assign req     = cyc_i && stb_i && !ack_o && !err_o;
   assign mapped  = (adr_i[1:0] == 2'h0) && (adr_i <= ALB_OFF_OFFSET);
   assign byte_op = dat_i[4:0] inside {5'h01, 5'h02, [5'h04:5'h07], [5'h09:5'h15], [5'h1D:5'h1F]};

   // opcode write accepted while idle
   sequence op_go(ok);
      req && we_i && sel_i[0] && !busy_o && adr_i == ALB_OFF_OPCODE && ok;
   endsequence

   ack_one_cycle_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   bus_answer_a: assert property (req |=> ack_o != err_o) else $error("request not answered once");
   unmapped_err_a: assert property (req && !mapped |=> err_o && !ack_o) else $error("unmapped not refused");
   idle_quiet_a: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o) else $error("answer without request");
   byte_one_a: assert property (op_go(byte_op) |=> busy_o ##1 !busy_o)
      else $error("byte op not one cycle");
   word_two_a: assert property (op_go(dat_i[4:0] inside {5'h03, 5'h08}) |=> busy_o [*2] ##1 !busy_o)
      else $error("word op not two cycles");
   goto_two_a: assert property (op_go(dat_i[4:0] inside {5'h16, 5'h17}) |=> busy_o [*2] ##1 !busy_o)
      else $error("jump not two cycles");
   call_three_a: assert property (op_go(dat_i[4:0] inside {5'h18, 5'h19}) |=> busy_o [*3] ##1 !busy_o)
      else $error("call not three cycles");
   return_four_a: assert property (op_go(dat_i[4:0] inside {5'h1A, 5'h1B}) |=> busy_o [*4] ##1 !busy_o)
      else $error("return not four cycles");
   skip_bound_a: assert property (op_go(dat_i[4:0] == 5'h1C) |=> busy_o ##[1:3] !busy_o)
      else $error("skip cycles out of range");
endmodule : alb_exec_chk

bind alb_exec alb_exec_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
   .busy_o(busy_o), .pc_o(pc_o));

// [verif/tb.sv]
// testbench: drives the execution slice over wishbone and judges results
module tb
   import alb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, busy_o;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [15:0] pc_o;
   int          fail_count, samples_checked, cycles;

   alb_exec uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .busy_o(busy_o), .pc_o(pc_o));

   task automatic end_of_test();
      if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
      q = dat_o;
      e = err_o;
      if (n >= 50) chk(1'b0, 1'b1, "bus answer timeout");
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] q;
      logic e;
      xfer(1'b0, a, 32'h0, q, e);
      chk(q, exp, msg);
   endtask : chk_reg

   task automatic run_op(input alb_op_e op);
      int n;
      wr(ALB_OFF_OPCODE, {27'h0, op});
      n = 0;
      while (busy_o !== 1'b0 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20) chk(1'b0, 1'b1, "operation never finished");
   endtask : run_op

   // {write back, flags, result}; byte operations leave the sign flag alone
   function automatic logic [16:0] model(input alb_op_e op, input logic [7:0] d, input logic [7:0] s,
                                         input logic [7:0] fi);
      logic [8:0] t;
      logic [4:0] h;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] f;
      logic       cy;
      logic       bf;
      logic       sb;
      logic       ar;
      a  = (op == OP_TWOS_INVERSE) ? ALB_ALL_ZEROS : d;
      b  = (op == OP_TWOS_INVERSE) ? d : s;
      bf = op inside {OP_MINUS_REGS_BOR, OP_MINUS_IMM_BOR, OP_COMPARE_BORROW};
      sb = bf || (op inside {OP_MINUS_REGS, OP_MINUS_IMM, OP_COMPARE_PLAIN, OP_MINUS_IMM_CMP, OP_TWOS_INVERSE});
      ar = sb || (op inside {OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY});
      cy = (bf || op == OP_SUM_WITH_CARRY) && fi[ALB_F_C];
      t  = sb ? a - b - cy : a + b + cy;
      h  = sb ? a[3:0] - b[3:0] - cy : a[3:0] + b[3:0] + cy;
      case (op)
         OP_CONJ_REGS, OP_CONJ_IMM:                   t[7:0] = d & s;
         OP_DISJ_REGS, OP_DISJ_IMM, OP_BITS_SET_MASK: t[7:0] = d | s;
         OP_XOR_REGS:                                 t[7:0] = d ^ s;
         OP_ONES_INVERSE:                             t[7:0] = ALB_ALL_ONES - d;
         OP_BITS_CLR_MASK:                            t[7:0] = d & (ALB_ALL_ONES - s);
         OP_PLUS_ONE:                                 t[7:0] = d + 8'h01;
         OP_MINUS_ONE:                                t[7:0] = d - 8'h01;
         OP_ZERO_SIGN_CHK:                            t[7:0] = d & d;
         OP_ZERO_REGISTER:                            t[7:0] = d ^ d;
         default:                                     ;
      endcase
      f = fi;
      f[ALB_F_Z] = (t[7:0] == 8'h00) && !(bf && !fi[ALB_F_Z]);
      f[ALB_F_N] = t[7];
      f[ALB_F_V] = (op == OP_PLUS_ONE && d == 8'h7F) || (op == OP_MINUS_ONE && d == 8'h80);
      if (op == OP_ONES_INVERSE) f[ALB_F_C] = 1'b1;
      if (ar) begin
         f[ALB_F_C] = t[8];
         f[ALB_F_H] = h[4];
         f[ALB_F_V] = (sb ? a[7] != b[7] : a[7] == b[7]) && t[7] != a[7];
      end
      return {!(op inside {OP_COMPARE_PLAIN, OP_MINUS_IMM_CMP, OP_COMPARE_BORROW}), f, t[7:0]};
   endfunction : model

   task automatic t_byte_ops();
      alb_op_e    op;
      logic [16:0] m;
      for (int i = 1; i < 32; i++) begin
         op = alb_op_e'(i);
         if (op inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM} || (i >= 5'h16 && i <= 5'h1C)) continue;
         wr(ALB_OFF_DEST, 32'h9C);
         wr(ALB_OFF_SRC, 32'h64);
         wr(ALB_OFF_FLAGS, 32'h03);
         run_op(op);
         m = model(op, 8'h9C, 8'h64, 8'h03);
         chk_reg(ALB_OFF_DEST, {24'h0, m[16] ? m[7:0] : 8'h9C}, op.name());
         chk_reg(ALB_OFF_FLAGS, {24'h0, m[15:8]}, op.name());
      end
   endtask : t_byte_ops

   task automatic t_word_ops();
      wr(ALB_OFF_DHIGH, 32'hFF);
      wr(ALB_OFF_DEST, 32'hF0);
      wr(ALB_OFF_SRC, 32'h20);
      wr(ALB_OFF_FLAGS, 32'h00);
      run_op(OP_WORD_PLUS_IMM);
      chk_reg(ALB_OFF_DHIGH, 32'h00, "word add high");
      chk_reg(ALB_OFF_DEST, 32'h10, "word add low");
      chk_reg(ALB_OFF_FLAGS, 32'h01, "word add flags");
      run_op(OP_WORD_MINUS_IMM);
      chk_reg(ALB_OFF_DHIGH, 32'hFF, "word sub high");
      chk_reg(ALB_OFF_DEST, 32'hF0, "word sub low");
      chk_reg(ALB_OFF_FLAGS, 32'h15, "word sub flags");
   endtask : t_word_ops

   task automatic t_flow_ops();
      wr(ALB_OFF_FLAGS, 32'h15);
      wr(ALB_OFF_PC, 32'h0100);
      wr(ALB_OFF_OFFSET, 32'hFFFF_FFF0);
      run_op(OP_REL_GOTO);
      chk(pc_o, 16'h00F1, "relative jump back");
      wr(ALB_OFF_OFFSET, 32'h10);
      run_op(OP_REL_SUBR_ENTRY);
      chk(pc_o, 16'h0102, "relative call");
      wr(ALB_OFF_ZPTR, 32'h1234);
      run_op(OP_PTR_GOTO);
      chk(pc_o, 16'h1234, "pointer jump");
      wr(ALB_OFF_ZPTR, 32'h0ABC);
      run_op(OP_PTR_SUBR_ENTRY);
      chk(pc_o, 16'h0ABC, "pointer call");
      chk_reg(ALB_OFF_FLAGS, 32'h15, "flags after flow");
      wr(ALB_OFF_STACK, 32'h0555);
      run_op(OP_SUBR_EXIT);
      chk(pc_o, 16'h0555, "subroutine return");
      wr(ALB_OFF_STACK, 32'h0777);
      run_op(OP_IRQ_EXIT);
      chk(pc_o, 16'h0777, "interrupt return");
   endtask : t_flow_ops

   task automatic t_skip_ops();
      logic [31:0] q;
      logic        e;
      wr(ALB_OFF_PC, 32'h0200);
      wr(ALB_OFF_DEST, 32'h5A);
      wr(ALB_OFF_SRC, 32'h5A);
      wr(ALB_OFF_STATUS, 32'h0);
      run_op(OP_EQUAL_SKIP);
      chk(pc_o, 16'h0202, "skip one word");
      chk_reg(ALB_OFF_STATUS, 32'h2, "skip taken");
      wr(ALB_OFF_STATUS, 32'h2);
      run_op(OP_EQUAL_SKIP);
      chk(pc_o, 16'h0205, "skip two words");
      wr(ALB_OFF_SRC, 32'h5B);
      run_op(OP_EQUAL_SKIP);
      chk(pc_o, 16'h0206, "no skip");
      chk_reg(ALB_OFF_STATUS, 32'h0, "skip not taken");
      xfer(1'b0, 8'h28, 32'h0, q, e);
      chk(e, 1'b1, "unmapped read");
   endtask : t_skip_ops

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
      adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_reg(ALB_OFF_DEST, 32'h0, "dest after reset");
      t_byte_ops();
      t_word_ops();
      t_flow_ops();
      t_skip_ops();
      end_of_test();
   end
endmodule : tb
